// *** hdl/pmc_clk_div.sv ***
`timescale 1ns/10ps
`include "pmc_map.svh"
module pmc_clk_div
  import pmc_pkg::*;
(
  input  wire logic clk,       // core clock
  input  wire logic rst_n,     // synchronised reset
  pmc_div_if.div    dif        // divider control and tick
);
  logic [`PMC_DIV_WIDTH-1:0] cnt_reg;
  logic [`PMC_DIV_WIDTH-1:0] cnt_next;
  logic                      tick_reg;
  logic                      tick_next;
  logic [`PMC_DIV_WIDTH-1:0] lim;

  // ************
  // divide by 1,2,4..128
  // ************
  always_comb begin
    lim       = 8'(({1'b0, 8'h01} << dif.div_sel) - 9'h001);
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (dif.run) begin
      if (cnt_reg >= lim) begin
        cnt_next  = 8'h00;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign dif.tick = tick_reg;

  tick_spacing_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tick_reg && dif.run && dif.div_sel == 3'h1 && $stable(dif.div_sel))
      |=> !tick_reg ##1 tick_reg) else $error("divide by 2 spacing wrong");
endmodule : pmc_clk_div

// *** hdl/pmc_ctrl.sv ***
`timescale 1ns/10ps
`include "pmc_map.svh"
// Operation
// - normal mode clocks core and the peripherals in use.
// - halt request stops core only; any interrupt wakes it.
// - digital peripheral clocks gated when peripheral not in use.
// - fast-wake sleep halts clocks, stops fast oscillators, regulator normal bias.
// - low-bias sleep halts clocks, stops fast oscillators, regulator low bias.
// - in sleep, timers 3 and 4 may run from slow oscillator.
// - sleep exits on timer4, SPI, I2C slave, port match, comparator fall, logic unit.
// - stop powers down internal nets, pins hold; any reset exits.
// - shutdown removes power, pins hold; only pin or power-on reset exits.
// - after reset system clock is 24.5 MHz oscillator divided by 8.
// - clock divider offers 1, 2, 4, 8, 16, 32, 64 or 128.
module pmc_ctrl
  import pmc_pkg::*;
(
  input  wire logic       CORE_CLK,         // 100 MHz clock
  input  wire logic       RESETN,           // async reset, active low
  input  wire logic [1:0] POWER_CONTROL_FIRST,  // halt / power-off request strobes
  input  wire logic       PCF_WRITE,        // write strobe for first control byte
  input  wire logic [1:0] POWER_CONTROL_SECOND, // fast / low-bias sleep requests
  input  wire logic       PCS_WRITE,        // write strobe for second control byte
  input  wire logic       SHUTDOWN_SELECT,  // regulator control select bit
  input  wire logic [2:0] DIV_SEL,          // system clock divide setting
  input  wire logic       DIV_WRITE,        // divider setting write strobe
  input  wire logic       CLK_SRC_24M,      // system clock on fast_osc_24m
  input  wire logic [7:0] PERIPH_IN_USE,    // per-peripheral enables
  input  wire logic       IRQ_PENDING,      // any interrupt request
  input  wire logic [5:0] WAKE_EVENTS,      // t4, spi, i2c, match, cmp0, clu (pins)
  input  wire logic       EXT_RESET_PIN,    // external reset pin seen
  input  wire logic       POR_SEEN,         // power-on reset seen
  input  wire logic       OTHER_RESET,      // any other reset source
  output logic            CORE_CLK_EN,      // core clock gate
  output logic [7:0]      PERIPH_CLK_EN,    // peripheral clock gates
  output logic            FAST_OSC_24M_EN,  // 24.5 MHz oscillator run
  output logic            FAST_OSC_49M_EN,  // 49 MHz oscillator run
  output logic            REG_LOW_BIAS,     // regulator low bias
  output logic            SLOW_TIMER_EN,    // timers 3/4 on slow oscillator
  output logic            POWER_NETS_OFF,   // internal power removed
  output logic            SYS_TICK,         // divided system clock enable
  output logic [2:0]      MODE              // current power mode
);
  logic       rs1_reg, rs2_reg;
  logic       rst_n;
  logic [5:0] w1_reg, w2_reg, w3_reg;
  pmc_mode_type mode_reg, mode_next;
  logic [2:0] div_reg, div_next;
  logic       core_en_reg, core_en_next;
  logic [7:0] per_en_reg, per_en_next;
  logic       o24_reg, o24_next, o49_reg, o49_next;
  logic       low_reg, low_next, slow_reg, slow_next, off_reg, off_next;
  logic       wake_hit;

  pmc_div_if dif ();

  // ************
  // reset release and wake input sync
  // ************
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rs1_reg <= 1'b0;
      rs2_reg <= 1'b0;
    end else begin
      rs1_reg <= 1'b1;
      rs2_reg <= rs1_reg;
    end
  end
  assign rst_n = rs2_reg;

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      w1_reg <= 6'h00;
      w2_reg <= 6'h00;
      w3_reg <= 6'h00;
    end else begin
      w1_reg <= WAKE_EVENTS;
      w2_reg <= w1_reg;
      w3_reg <= w2_reg;
    end
  end
  // level counts once second and third stages agree
  assign wake_hit = |(w2_reg & w3_reg);

  // ************
  // mode sequencer
  // ************
  always_comb begin
    mode_next = mode_reg;
    div_next  = div_reg;
    if (DIV_WRITE) begin
      div_next = DIV_SEL;
    end
    unique case (mode_reg)
      PMC_NORMAL: begin
        if (PCF_WRITE && POWER_CONTROL_FIRST[`PMC_PCF_OFF_BIT]) begin
          // select bit must already be set as intended before the request
          mode_next = SHUTDOWN_SELECT ? PMC_SHUTDOWN : PMC_STOP;
        end else if (PCF_WRITE && POWER_CONTROL_FIRST[`PMC_PCF_HALT_BIT]) begin
          mode_next = PMC_IDLE;
        end else if (PCS_WRITE && CLK_SRC_24M) begin
          if (POWER_CONTROL_SECOND[`PMC_PCS_LOW_BIT]) begin
            mode_next = PMC_SNOOZE;
          end else if (POWER_CONTROL_SECOND[`PMC_PCS_FAST_BIT]) begin
            mode_next = PMC_SUSPEND;
          end
        end
      end
      PMC_IDLE: begin
        if (IRQ_PENDING) begin
          mode_next = PMC_NORMAL;
        end
      end
      PMC_SUSPEND, PMC_SNOOZE: begin
        if (wake_hit) begin
          mode_next = PMC_NORMAL;
        end
      end
      PMC_STOP: begin
        if (EXT_RESET_PIN || POR_SEEN || OTHER_RESET) begin
          mode_next = PMC_NORMAL;
          div_next  = `PMC_DIV_RESET;
        end
      end
      PMC_SHUTDOWN: begin
        // other reset sources are ignored: power is gone
        if (EXT_RESET_PIN || POR_SEEN) begin
          mode_next = PMC_NORMAL;
          div_next  = `PMC_DIV_RESET;
        end
      end
      default: mode_next = PMC_NORMAL;
    endcase
  end

  // ************
  // output decode
  // ************
  always_comb begin
    core_en_next = 1'b1;
    per_en_next  = PERIPH_IN_USE;
    o24_next     = 1'b1;
    o49_next     = 1'b1;
    low_next     = 1'b0;
    slow_next    = 1'b0;
    off_next     = 1'b0;
    unique case (mode_next)
      PMC_NORMAL: ;
      PMC_IDLE: core_en_next = 1'b0;
      PMC_SUSPEND, PMC_SNOOZE: begin
        core_en_next = 1'b0;
        per_en_next  = 8'h00;
        o24_next     = 1'b0;
        o49_next     = 1'b0;
        low_next     = (mode_next == PMC_SNOOZE);
        slow_next    = 1'b1;
      end
      PMC_STOP, PMC_SHUTDOWN: begin
        core_en_next = 1'b0;
        per_en_next  = 8'h00;
        o24_next     = 1'b0;
        o49_next     = 1'b0;
        off_next     = 1'b1;
      end
      default: ;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg    <= PMC_NORMAL;
      div_reg     <= `PMC_DIV_RESET;
      core_en_reg <= 1'b1;
      per_en_reg  <= 8'h00;
      o24_reg     <= 1'b1;
      o49_reg     <= 1'b1;
      low_reg     <= 1'b0;
      slow_reg    <= 1'b0;
      off_reg     <= 1'b0;
    end else begin
      mode_reg    <= mode_next;
      div_reg     <= div_next;
      core_en_reg <= core_en_next;
      per_en_reg  <= per_en_next;
      o24_reg     <= o24_next;
      o49_reg     <= o49_next;
      low_reg     <= low_next;
      slow_reg    <= slow_next;
      off_reg     <= off_next;
    end
  end

  // divider halts with the fast oscillators
  assign dif.div_sel = div_reg;
  assign dif.run     = o24_reg;

  pmc_clk_div u_div (
    .clk   (CORE_CLK),
    .rst_n (rst_n),
    .dif   (dif.div)
  );

  always_comb begin
    CORE_CLK_EN     = core_en_reg;
    PERIPH_CLK_EN   = per_en_reg;
    FAST_OSC_24M_EN = o24_reg;
    FAST_OSC_49M_EN = o49_reg;
    REG_LOW_BIAS    = low_reg;
    SLOW_TIMER_EN   = slow_reg;
    POWER_NETS_OFF  = off_reg;
    SYS_TICK        = dif.tick;
    MODE            = mode_reg;
  end

  // ************
  // checks
  // ************
  sequence sleep_req_s;
    mode_reg == PMC_NORMAL && PCS_WRITE && CLK_SRC_24M
      && POWER_CONTROL_SECOND == 2'b01 && !PCF_WRITE;
  endsequence

  idle_entry_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (mode_reg == PMC_NORMAL && PCF_WRITE && POWER_CONTROL_FIRST == 2'b01)
      |=> (mode_reg == PMC_IDLE && !CORE_CLK_EN && PERIPH_CLK_EN == $past(PERIPH_IN_USE)))
    else $error("idle entry wrong");
  suspend_entry_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    sleep_req_s |=> (!FAST_OSC_24M_EN && !FAST_OSC_49M_EN && !REG_LOW_BIAS && SLOW_TIMER_EN))
    else $error("suspend outputs wrong");
  snooze_bias_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (mode_reg == PMC_SNOOZE) |-> REG_LOW_BIAS) else $error("snooze bias not low");
  sleep_wake_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    ((mode_reg == PMC_SUSPEND || mode_reg == PMC_SNOOZE) && wake_hit)
      |=> (mode_reg == PMC_NORMAL && CORE_CLK_EN)) else $error("sleep did not wake");
  sleep_gate_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (mode_reg == PMC_NORMAL && PCS_WRITE && !CLK_SRC_24M && !PCF_WRITE)
      |=> mode_reg == PMC_NORMAL) else $error("sleep taken off wrong clock");
  shut_hold_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (mode_reg == PMC_SHUTDOWN && !EXT_RESET_PIN && !POR_SEEN)
      |=> (mode_reg == PMC_SHUTDOWN && POWER_NETS_OFF)) else $error("shutdown left");
  stop_exit_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (mode_reg == PMC_STOP && OTHER_RESET) |=> (mode_reg == PMC_NORMAL && !POWER_NETS_OFF))
    else $error("stop did not exit");
  normal_run_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (mode_reg == PMC_NORMAL) |-> (CORE_CLK_EN && FAST_OSC_24M_EN))
    else $error("normal mode gated");
  reset_div_a: assert property (@(posedge CORE_CLK)
    $rose(rst_n) |-> (div_reg == 3'h3 && mode_reg == PMC_NORMAL))
    else $error("reset divider not 8");
endmodule : pmc_ctrl

// *** hdl/pmc_div_if.sv ***
`timescale 1ns/10ps
interface pmc_div_if;
  logic [2:0] div_sel;
  logic       run;
  logic       tick;
  modport ctrl (output div_sel, output run, input tick);
  modport div  (input div_sel, input run, output tick);
endinterface : pmc_div_if

// *** hdl/pmc_map.svh ***
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH
// control bit positions (first power control byte)
`define PMC_PCF_HALT_BIT    0
`define PMC_PCF_OFF_BIT     1
// control bit positions (second power control byte)
`define PMC_PCS_FAST_BIT    0
`define PMC_PCS_LOW_BIT     1
// clock divider: setting 3 is divide by 8
`define PMC_DIV_RESET       3'h3
`define PMC_DIV_WIDTH       8
// wake source count
`define PMC_WAKE_COUNT      6
`endif

// *** hdl/pmc_pkg.sv ***
package pmc_pkg;
  typedef enum logic [2:0] {
    PMC_NORMAL, PMC_IDLE, PMC_SUSPEND, PMC_SNOOZE, PMC_STOP, PMC_SHUTDOWN
  } pmc_mode_type;
endpackage : pmc_pkg

// *** tb/pmc_ctrl_tb_top.sv ***
`timescale 1ns/10ps
module pmc_ctrl_tb_top import pmc_pkg::*; ;
  // ****************
  // signals
  // ****************
  logic       core_clk = 1'b0, resetn = 1'b0, pcf_wr = 1'b0, pcs_wr = 1'b0;
  logic       sd_sel = 1'b0, div_wr = 1'b0, src24 = 1'b1, fire = 1'b0;
  logic [1:0] pcf = 2'h0, pcs = 2'h0;
  logic [2:0] div_sel = 3'h3;
  logic [3:0] src = 4'h0;
  logic [7:0] in_use = 8'h00, pclk;
  logic [5:0] wake;
  logic       irq, pin_rst, por, oth_rst, core_en, osc24, osc49, low_bias, slow_t, nets_off;
  logic       tick;
  logic [2:0] mode;
  int         miscompares = 0, n_checks = 0, c;
  initial forever #5 core_clk = ~core_clk;
  pmc_far_model u_pmc_far_model (.clk(core_clk), .fire(fire), .src(src), .wake(wake),
    .irq(irq), .pin_rst(pin_rst), .por(por), .oth_rst(oth_rst));
  pmc_ctrl u_pmc_ctrl (.CORE_CLK(core_clk), .RESETN(resetn), .POWER_CONTROL_FIRST(pcf),
    .PCF_WRITE(pcf_wr), .POWER_CONTROL_SECOND(pcs), .PCS_WRITE(pcs_wr),
    .SHUTDOWN_SELECT(sd_sel), .DIV_SEL(div_sel), .DIV_WRITE(div_wr), .CLK_SRC_24M(src24),
    .PERIPH_IN_USE(in_use), .IRQ_PENDING(irq), .WAKE_EVENTS(wake), .EXT_RESET_PIN(pin_rst),
    .POR_SEEN(por), .OTHER_RESET(oth_rst), .CORE_CLK_EN(core_en), .PERIPH_CLK_EN(pclk),
    .FAST_OSC_24M_EN(osc24), .FAST_OSC_49M_EN(osc49), .REG_LOW_BIAS(low_bias),
    .SLOW_TIMER_EN(slow_t), .POWER_NETS_OFF(nets_off), .SYS_TICK(tick), .MODE(mode));
  // ****************
  // helpers
  // ****************
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task wait_mode(input pmc_mode_type m);
    int i;
    i = 0;
    while (mode !== m && i < 40) begin
      step(1);
      i++;
    end
    if (mode !== m) begin
      miscompares++;
      $display("Error mode wait expected %0d seen %0d", m, mode);
      end_sim();
    end
  endtask : wait_mode
  task ticks(input int n);
    c = 0;
    repeat (n) begin
      step(1);
      if (tick === 1'b1) c++;
    end
  endtask : ticks
  task wr(input logic sel, input logic [1:0] v);
    @(posedge core_clk);
    if (sel) begin pcs <= v; pcs_wr <= 1'b1; end
    else begin pcf <= v; pcf_wr <= 1'b1; end
    @(posedge core_clk);
    pcs_wr <= 1'b0;
    pcf_wr <= 1'b0;
    // let the edge settle before callers look at outputs
    #1;
  endtask : wr
  task ev(input logic [3:0] s);
    @(posedge core_clk);
    fire <= 1'b1;
    src  <= s;
    @(posedge core_clk);
    fire <= 1'b0;
    step(1);
  endtask : ev
  // ****************
  // scenarios
  // ****************
  task t_reset;
    chk("mode", 16'(mode), 16'h0000);
    chk("gates", {core_en, osc24, osc49, low_bias, nets_off}, 16'h001C);
    ticks(64);
    chk("div8 ticks", 16'(c), 16'h0008);
    $display("test reset done");
  endtask : t_reset
  task t_idle;
    @(posedge core_clk);
    in_use <= 8'hA5;
    step(3);
    chk("periph gate", 16'(pclk), 16'h00A5);
    wr(1'b0, 2'h1);
    wait_mode(PMC_IDLE);
    chk("idle core", 16'(core_en), 16'h0000);
    chk("idle periph", 16'(pclk), 16'h00A5);
    ev(4'h6);
    wait_mode(PMC_NORMAL);
    chk("normal core", 16'(core_en), 16'h0001);
    $display("test idle done");
  endtask : t_idle
  task t_sleep;
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      src24 <= 1'b1;
      // last pass sets both sleep bits: low-bias sleep must win
      wr(1'b1, (i == 5) ? 2'h3 : (i[0] ? 2'h2 : 2'h1));
      wait_mode(i[0] ? PMC_SNOOZE : PMC_SUSPEND);
      chk("sleep gates", {core_en, pclk, osc24, osc49}, 16'h0000);
      chk("sleep bias", 16'(low_bias), 16'(i[0]));
      chk("slow timers", 16'(slow_t), 16'h0001);
      ticks(16);
      chk("sleep ticks", 16'(c), 16'h0000);
      ev(4'(i));
      wait_mode(PMC_NORMAL);
      chk("woken core", 16'(core_en), 16'h0001);
      step(8);
    end
    @(posedge core_clk);
    src24 <= 1'b0;
    wr(1'b1, 2'h1);
    step(5);
    chk("sleep refused", 16'(mode), 16'h0000);
    $display("test sleep done");
  endtask : t_sleep
  task t_div;
    for (int n = 0; n < 8; n++) begin
      @(posedge core_clk);
      src24   <= 1'b1;
      div_sel <= 3'(n);
      div_wr  <= 1'b1;
      @(posedge core_clk);
      div_wr <= 1'b0;
      step(4);
      ticks(256);
      chk("div ticks", 16'(c), 16'(256 >> n));
    end
    $display("test divider done");
  endtask : t_div
  task t_power;
    @(posedge core_clk);
    sd_sel <= 1'b0;
    // halt bit set too: power-off request must take priority
    wr(1'b0, 2'h3);
    wait_mode(PMC_STOP);
    chk("stop nets", 16'(nets_off), 16'h0001);
    ev(4'h9);
    wait_mode(PMC_NORMAL);
    ticks(64);
    chk("div back to 8", 16'(c), 16'h0008);
    for (int k = 7; k < 9; k++) begin
      @(posedge core_clk);
      sd_sel <= 1'b1;
      wr(1'b0, 2'h2);
      wait_mode(PMC_SHUTDOWN);
      chk("shut nets", 16'(nets_off), 16'h0001);
      ev(4'h9);
      step(10);
      chk("shut holds", 16'(mode), 16'h0005);
      ev(4'(k));
      wait_mode(PMC_NORMAL);
      step(8);
    end
    $display("test power off done");
  endtask : t_power
  task t_rerst;
    @(posedge core_clk);
    div_wr <= 1'b1;
    @(posedge core_clk);
    div_wr <= 1'b0;
    wr(1'b0, 2'h1);
    wait_mode(PMC_IDLE);
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    step(3);
    chk("rerst mode", 16'(mode), 16'h0000);
    chk("rerst gates", {core_en, osc24, osc49, low_bias, nets_off}, 16'h001C);
    ticks(64);
    chk("rerst div8", 16'(c), 16'h0008);
    $display("test mid reset done");
  endtask : t_rerst
  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    step(3);
    t_reset();
    t_idle();
    t_sleep();
    t_div();
    t_power();
    t_rerst();
    end_sim();
  end
endmodule : pmc_ctrl_tb_top

// *** tb/pmc_far_model.sv ***
`timescale 1ns/10ps
module pmc_far_model (
  input  wire logic       clk,      // core clock
  input  wire logic       fire,     // one-cycle event request
  input  wire logic [3:0] src,      // 0-5 wake, 6 irq, 7 pin, 8 por, 9 other reset
  output logic      [5:0] wake,     // wake event levels
  output logic            irq,      // interrupt pending
  output logic            pin_rst,  // external reset pin
  output logic            por,      // power-on reset
  output logic            oth_rst   // any other reset source
);
  logic [9:0] lvl_reg  = 10'h000;
  logic [2:0] hold_reg = 3'h0;
  // levels stand 7 cycles: long enough to pass the 3-flop wake sync
  always @(posedge clk) begin
    if (fire) begin
      lvl_reg  <= 10'h001 << src;
      hold_reg <= 3'h6;
    end else if (hold_reg != 3'h0) begin
      hold_reg <= hold_reg - 3'h1;
    end else begin
      lvl_reg <= 10'h000;
    end
  end
  assign wake    = lvl_reg[5:0];
  assign irq     = lvl_reg[6];
  assign pin_rst = lvl_reg[7];
  assign por     = lvl_reg[8];
  assign oth_rst = lvl_reg[9];
endmodule : pmc_far_model
